// ==== mem_addr_defs.svh ====
// Constants for the memory/device address register group.
// Assumes inclusion by bare name; definitions only.
`ifndef MEM_ADDR_DEFS_SVH
`define MEM_ADDR_DEFS_SVH

// Wishbone register offsets (byte addresses)
`define OFS_CTRL        8'h00
`define OFS_ADDR_LOW    8'h04
`define OFS_BASE_ONE    8'h08
`define OFS_BASE_TWO    8'h0C
`define OFS_ADDR_OUT    8'h10
`define OFS_COUNT_LIT   8'h14

// Control register field positions
`define CTRL_BIT_BASE_TWO 0

// Reset values
`define RST_BYTE        8'h00
`define RST_CTRL        1'h0

`endif

// ==== mem_addr_pkg.sv ====
// Types for the memory/device address register group.
// Assumes nothing beyond a SystemVerilog compiler.
package mem_addr_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [31:0] bus_word_t;
  typedef logic [5:0]  bus_addr_t;
  typedef logic [3:0]  sel_t;
endpackage : mem_addr_pkg

// ==== memory_device_address_regs.sv ====
// Address-forming registers of the memory control unit: low address, two
// base registers, loop counter and literal byte, with a Wishbone slave view.
// Assumes one clock; the phase 3 clock arrives as a one-cycle enable.
//
// Functional notes
// [RULE1] Eight-bit low register forms low address byte
// [RULE2] Full address is base byte over low byte
// [RULE3] Low register holds, loads literal or shifter
// [RULE4] Low register loads only on phase 3
// [RULE5] First base register, eight bits wide
// [RULE6] First base loads shifter byte one on phase 3
// [RULE7] Second base loads shifter top byte
// [RULE8] Base strobes gate enables with phase 3
// [RULE9] Output picks first base unless base-two selected
// [RULE10] Output is memory or device address
// [RULE11] Output feeds Y multiplexer and memory path
// [RULE12] Base output bits feed port selector
// [RULE13] Count/literal word is counter over literal
// [RULE14] Counter holds, loads, or increments modulo 256
// [RULE15] Literal loads store bits 9-16 on transfer
// [RULE16] Address registers clear to zero at reset
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`include "mem_addr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module memory_device_address_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Microcode control bits
  input  wire logic                     third_phase_clock,
  input  wire logic                     addr_low_load_en,
  input  wire logic                     addr_low_src_sel,
  input  wire logic                     base_one_load_en,
  input  wire logic                     base_two_load_en,
  input  wire logic                     count_load_en,
  input  wire logic                     count_inc_en,
  input  wire logic                     base_two_pick,
  input  wire logic                     immediate_load,
  input  wire mem_addr_pkg::word_t      micro_store,
  input  wire mem_addr_pkg::bus_word_t  barrel_shifter_out,
  // Address outputs
  output logic [15:0]                   output_select_bits,
  output logic [15:0]                   y_operand_addr,
  output logic [15:0]                   memory_addr,
  output logic [7:0]                    port_select_addr,
  output logic [7:0]                    device_addr,
  output logic [15:0]                   count_literal_word,
  output logic                          count_overflow,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire mem_addr_pkg::bus_addr_t  wb_adr_i,
  input  wire mem_addr_pkg::sel_t       wb_sel_i,
  input  wire mem_addr_pkg::bus_word_t  wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o
);
  import mem_addr_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Storage
  byte_t addr_low_reg;
  byte_t base_reg_one;
  byte_t base_reg_two;
  byte_t loop_count_reg;
  byte_t immediate_byte_reg;
  logic  sw_base_two_reg;
  logic  ovf_reg;
  logic  ack_reg;
  bus_word_t rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // Strobes and source selection
  wire   addr_low_strobe = addr_low_load_en & third_phase_clock;   // [RULE4]
  wire   base_one_strobe = base_one_load_en & third_phase_clock;   // [RULE8]
  wire   base_two_strobe = base_two_load_en & third_phase_clock;   // [RULE8]
  wire byte_t shifter_low  = barrel_shifter_out[7:0];
  wire byte_t shifter_next = barrel_shifter_out[15:8];
  wire byte_t shifter_top  = barrel_shifter_out[31:24];
  // Shared input select gates for low register and counter
  wire byte_t addr_low_from_immediate = immediate_byte_reg;
  wire byte_t shared_src = addr_low_src_sel ? shifter_low
                                            : addr_low_from_immediate; // [RULE3]
  wire   use_base_two = base_two_pick | sw_base_two_reg;
  wire byte_t base_pick = use_base_two ? base_reg_two : base_reg_one; // [RULE9]

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire       wb_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire [7:0] wb_ofs   = {wb_adr_i, 2'h0};
  // Control writes land at the edge where ack is seen high, while the master
  // still holds the request; ack stands one cycle, so one write per request
  wire       wr_ctrl  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0]
                        & (wb_ofs == `OFS_CTRL);
  wire       hit_ctrl = (wb_ofs == `OFS_CTRL);
  bus_word_t rd_mux;
  assign rd_mux =
    hit_ctrl                    ? {31'h0, sw_base_two_reg} :
    (wb_ofs == `OFS_ADDR_LOW)   ? {24'h0, addr_low_reg} :
    (wb_ofs == `OFS_BASE_ONE)   ? {24'h0, base_reg_one} :
    (wb_ofs == `OFS_BASE_TWO)   ? {24'h0, base_reg_two} :
    (wb_ofs == `OFS_ADDR_OUT)   ? {16'h0, output_select_bits} :
    (wb_ofs == `OFS_COUNT_LIT)  ? {15'h0, ovf_reg, count_literal_word} :
                                  32'h0;

  //////////////////////////////////////////////////////////////////////////
  // Low-address register; holds when not strobed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_low_reg <= `RST_BYTE;                                   // [RULE16]
    end else if (addr_low_strobe) begin
      addr_low_reg <= shared_src;                                  // [RULE3]
    end
  end

  // Base registers load from their own shifter bytes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_reg_one <= `RST_BYTE;                                   // [RULE16]
      base_reg_two <= `RST_BYTE;
    end else begin
      if (base_one_strobe) base_reg_one <= shifter_next;           // [RULE6]
      if (base_two_strobe) base_reg_two <= shifter_top;            // [RULE7]
    end
  end

  // Loop counter: load overrides increment; wraps modulo 256
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_count_reg <= `RST_BYTE;
      ovf_reg        <= 1'b0;
    end else if (count_load_en) begin
      loop_count_reg <= shared_src;                                // [RULE14]
      ovf_reg        <= 1'b0;
    end else if (count_inc_en) begin
      loop_count_reg <= loop_count_reg + 8'h01;                    // [RULE14]
      if (loop_count_reg == 8'hFF) ovf_reg <= 1'b1;
    end
  end

  // Literal byte from store bits 9-16 (low byte of the store word)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      immediate_byte_reg <= `RST_BYTE;
    end else if (immediate_load) begin
      immediate_byte_reg <= micro_store[7:0];                      // [RULE15]
    end
  end

  // Wishbone slave: one ack per request, registered a cycle later, dropped next cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg         <= 1'b0;
      rdata_reg       <= 32'h0;
      sw_base_two_reg <= `RST_CTRL;
    end else begin
      ack_reg   <= wb_req;
      rdata_reg <= rd_mux;
      if (wr_ctrl) sw_base_two_reg <= wb_dat_i[`CTRL_BIT_BASE_TWO];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs; the low byte always sits at the least significant end
  assign output_select_bits = {base_pick, addr_low_reg};           // [RULE1] [RULE2]
  assign y_operand_addr     = output_select_bits;                  // [RULE11]
  assign memory_addr        = output_select_bits;                  // [RULE10] [RULE11]
  assign device_addr        = addr_low_reg;                        // [RULE10]
  assign port_select_addr   = base_pick;                           // [RULE12] [RULE5]
  assign count_literal_word = {loop_count_reg, immediate_byte_reg};// [RULE13]
  assign count_overflow     = ovf_reg;
  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_low_load;
    @(posedge clk) disable iff (!rst_n)
    (addr_low_load_en & third_phase_clock) |=> addr_low_reg == $past(shared_src);
  endproperty
  a_low_load: assert property (p_low_load) else $error("low load wrong"); // [RULE3]

  property p_low_hold;
    @(posedge clk) disable iff (!rst_n)
    !(addr_low_load_en & third_phase_clock) |=> $stable(addr_low_reg);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low held badly"); // [RULE4]

  property p_base_one;
    @(posedge clk) disable iff (!rst_n)
    (base_one_load_en & third_phase_clock) |=>
      base_reg_one == $past(barrel_shifter_out[15:8]);
  endproperty
  a_base_one: assert property (p_base_one) else $error("base one load"); // [RULE6]

  property p_base_two;
    @(posedge clk) disable iff (!rst_n)
    (base_two_load_en & third_phase_clock) |=>
      base_reg_two == $past(barrel_shifter_out[31:24]);
  endproperty
  a_base_two: assert property (p_base_two) else $error("base two load"); // [RULE7]

  property p_base_gate;
    @(posedge clk) disable iff (!rst_n)
    !third_phase_clock |=> $stable(base_reg_one) && $stable(base_reg_two);
  endproperty
  a_base_gate: assert property (p_base_gate) else $error("base off phase"); // [RULE8]

  property p_pick;
    @(posedge clk) disable iff (!rst_n)
    output_select_bits[15:8] ==
      ((base_two_pick | sw_base_two_reg) ? base_reg_two : base_reg_one);
  endproperty
  a_pick: assert property (p_pick) else $error("base pick wrong"); // [RULE9]

  property p_low_end;
    @(posedge clk) disable iff (!rst_n)
    output_select_bits[7:0] == addr_low_reg && memory_addr == y_operand_addr;
  endproperty
  a_low_end: assert property (p_low_end) else $error("address layout"); // [RULE2]

  property p_port;
    @(posedge clk) disable iff (!rst_n)
    port_select_addr == output_select_bits[15:8];
  endproperty
  a_port: assert property (p_port) else $error("port address"); // [RULE12]

  property p_inc;
    @(posedge clk) disable iff (!rst_n)
    (count_inc_en & !count_load_en) |=> loop_count_reg == $past(loop_count_reg) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("counter increment"); // [RULE14]

  property p_lit;
    @(posedge clk) disable iff (!rst_n)
    immediate_load |=> count_literal_word[7:0] == $past(micro_store[7:0]);
  endproperty
  a_lit: assert property (p_lit) else $error("literal load"); // [RULE15]

  sequence s_req;
    wb_cyc_i & wb_stb_i & !wb_ack_o;
  endsequence
  property p_ack;
    @(posedge clk) disable iff (!rst_n)
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing"); // Wishbone ack timing, decided for this implementation

  property p_reset;
    @(posedge clk)
    !rst_n |=> addr_low_reg == 8'h00 && base_reg_one == 8'h00 && base_reg_two == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value"); // [RULE16]

  // Source choice of the low register, one property per select value
  property p_low_from_lit;
    @(posedge clk) disable iff (!rst_n)
    (addr_low_load_en & third_phase_clock & !addr_low_src_sel) |=> addr_low_reg == $past(immediate_byte_reg);
  endproperty
  a_low_from_lit: assert property (p_low_from_lit) else $error("low from literal"); // [RULE3]

  property p_low_from_shift;
    @(posedge clk) disable iff (!rst_n)
    (addr_low_load_en & third_phase_clock & addr_low_src_sel) |=> addr_low_reg == $past(shifter_low);
  endproperty
  a_low_from_shift: assert property (p_low_from_shift) else $error("low from shifter"); // [RULE3]

  // Base registers keep their contents while their own enable is low
  property p_base_one_hold;
    @(posedge clk) disable iff (!rst_n)
    !base_one_load_en |=> $stable(base_reg_one);
  endproperty
  a_base_one_hold: assert property (p_base_one_hold) else $error("base one held"); // [RULE6]

  property p_base_two_hold;
    @(posedge clk) disable iff (!rst_n)
    !base_two_load_en |=> $stable(base_reg_two);
  endproperty
  a_base_two_hold: assert property (p_base_two_hold) else $error("base two held"); // [RULE7]

  // Default and forced base selection on the address output
  property p_base_default;
    @(posedge clk) disable iff (!rst_n)
    (!base_two_pick && !sw_base_two_reg) |-> port_select_addr == base_reg_one;
  endproperty
  a_base_default: assert property (p_base_default) else $error("base one default"); // [RULE5]

  property p_base_two_sel;
    @(posedge clk) disable iff (!rst_n)
    base_two_pick |-> output_select_bits[15:8] == base_reg_two;
  endproperty
  a_base_two_sel: assert property (p_base_two_sel) else $error("base two select"); // [RULE9]

  // Address copies toward the operand path, memory and devices
  property p_device;
    @(posedge clk) disable iff (!rst_n)
    device_addr == output_select_bits[7:0];
  endproperty
  a_device: assert property (p_device) else $error("device address"); // [RULE10]

  property p_y_copy;
    @(posedge clk) disable iff (!rst_n)
    y_operand_addr == output_select_bits && memory_addr == output_select_bits;
  endproperty
  a_y_copy: assert property (p_y_copy) else $error("address copies"); // [RULE11]

  // Count/literal word layout
  property p_count_word;
    @(posedge clk) disable iff (!rst_n)
    count_literal_word == {loop_count_reg, immediate_byte_reg};
  endproperty
  a_count_word: assert property (p_count_word) else $error("count word layout"); // [RULE13]

  // Counter: hold, load with overflow clear, and wrap from all ones
  property p_count_hold;
    @(posedge clk) disable iff (!rst_n)
    (!count_inc_en && !count_load_en) |=> $stable(loop_count_reg);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter held"); // [RULE14]

  property p_count_load;
    @(posedge clk) disable iff (!rst_n)
    count_load_en |=> loop_count_reg == $past(shared_src);
  endproperty
  a_count_load: assert property (p_count_load) else $error("counter load"); // [RULE14]

  property p_ovf_clear;
    @(posedge clk) disable iff (!rst_n)
    count_load_en |=> !count_overflow;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow clear"); // [RULE14]

  property p_wrap;
    @(posedge clk) disable iff (!rst_n)
    (count_inc_en && !count_load_en && loop_count_reg == 8'hFF) |=> loop_count_reg == 8'h00 && count_overflow;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap"); // [RULE14]

  // Literal byte only changes on its transfer signal
  property p_lit_hold;
    @(posedge clk) disable iff (!rst_n)
    !immediate_load |=> $stable(immediate_byte_reg);
  endproperty
  a_lit_hold: assert property (p_lit_hold) else $error("literal held"); // [RULE15]

  // Counter, flag and bus answer also start clean after reset
  property p_reset_count;
    @(posedge clk)
    !rst_n |=> loop_count_reg == 8'h00 && !count_overflow && !wb_ack_o;
  endproperty
  a_reset_count: assert property (p_reset_count) else $error("counter reset"); // [RULE16]

endmodule : memory_device_address_regs
`default_nettype wire

// ==== micro_control_model.sv ====
// Far-side model: microcode phase sequencer, shifter and store words.
// Assumes the bench supplies raw shifter and store values each cycle.
`timescale 1ns/1ps
`default_nettype none

module micro_control_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Raw values from the bench
  input  wire logic [31:0] shift_raw,
  input  wire logic [15:0] store_raw,
  // Toward the address group
  output logic             third_phase_clock,
  output logic [31:0]      barrel_shifter_out,
  output logic [15:0]      micro_store
);
  logic [1:0] phase_reg;

  // Four phases per microinstruction; data is registered like a real datapath
  always_ff @(posedge clk) begin
    if (!rst_n) phase_reg <= 2'h0;
    else phase_reg <= phase_reg + 2'h1;
    barrel_shifter_out <= shift_raw;
    micro_store        <= store_raw;
  end

  // Phase 3 is a single-cycle pulse once per microinstruction
  assign third_phase_clock = (phase_reg == 2'h2);
endmodule : micro_control_model

`default_nettype wire

// ==== test_memory_device_address_regs.sv ====
// Self-checking bench for the address register group.
// Assumes mem_addr_pkg and the partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_memory_device_address_regs;
  import mem_addr_pkg::*;
  logic      clk, rst_n, ld_lo, src, ld_b1, ld_b2, ld_c, inc_c, pick, ld_lit, chk;
  logic      cyc, stb, we;
  bus_addr_t adr;
  sel_t      sel;
  bus_word_t wdat, sh_raw, seed;
  word_t     st_raw;
  wire logic ph3, ack, ovf;
  wire bus_word_t bso, dat_o;
  wire word_t ms, osb, yad, mad, clw;
  wire byte_t psa, dva;
  byte_t     m_lo, m_b1, m_b2, m_cnt, m_lit;
  logic      m_ovf, m_ctl;
  int        err_count, n_tests;
  wire word_t e_out = {((m_ctl | pick) ? m_b2 : m_b1), m_lo};

  micro_control_model micro_control_model_inst (.clk(clk), .rst_n(rst_n),
    .shift_raw(sh_raw), .store_raw(st_raw), .third_phase_clock(ph3),
    .barrel_shifter_out(bso), .micro_store(ms));

  memory_device_address_regs memory_device_address_regs_inst (.clk(clk), .rst_n(rst_n),
    .third_phase_clock(ph3), .addr_low_load_en(ld_lo), .addr_low_src_sel(src),
    .base_one_load_en(ld_b1), .base_two_load_en(ld_b2), .count_load_en(ld_c),
    .count_inc_en(inc_c), .base_two_pick(pick), .immediate_load(ld_lit),
    .micro_store(ms), .barrel_shifter_out(bso), .output_select_bits(osb),
    .y_operand_addr(yad), .memory_addr(mad), .port_select_addr(psa),
    .device_addr(dva), .count_literal_word(clw), .count_overflow(ovf),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));

  ////////////////////////////////////////////////////////////////////////////
  function automatic bus_word_t xs(input bus_word_t v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic report_and_stop;
    $display("Checks: %0d mismatches: %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input bus_word_t ex, input bus_word_t got);
    n_tests++;
    if (got !== ex) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  // One classic cycle; the wait is bounded so a silent slave ends the run
  task automatic wb(input logic w, input bus_addr_t a, input bus_word_t d, input bus_word_t e);
    int i;
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    for (i = 0; i < 20 && ack !== 1'h1; i++) @(posedge clk);
    if (i == 20) begin
      err_count++;
      report_and_stop();
    end
    if (!w) check("wb_read", e, dat_o);
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
    @(posedge clk);
  endtask : wb

  ////////////////////////////////////////////////////////////////////////////
  // Reference registers; old literal value feeds loads of the same edge
  always @(posedge clk) begin
    if (!rst_n) {m_lo, m_b1, m_b2, m_cnt, m_lit, m_ovf, m_ctl} = '0;
    else begin
      if (ld_lo && ph3) m_lo = src ? bso[7:0] : m_lit;
      if (ld_b1 && ph3) m_b1 = bso[15:8];
      if (ld_b2 && ph3) m_b2 = bso[31:24];
      if (ld_c) {m_ovf, m_cnt} = {1'h0, src ? bso[7:0] : m_lit};
      else if (inc_c) {m_ovf, m_cnt} = {m_ovf | (m_cnt == 8'hFF), m_cnt + 8'h01};
      if (ld_lit) m_lit = ms[7:0];
      if (ack && cyc && stb && we && adr == 6'h00 && sel[0]) m_ctl = wdat[0];
    end
  end

  // Outputs are compared mid-cycle, once settled
  always @(negedge clk) if (chk) begin
    check("output_select_bits", {16'h0, e_out}, {16'h0, osb});
    check("y_operand_addr", {16'h0, e_out}, {16'h0, yad});
    check("memory_addr", {16'h0, e_out}, {16'h0, mad});
    check("port_select_addr", {24'h0, e_out[15:8]}, {24'h0, psa});
    check("device_addr", {24'h0, m_lo}, {24'h0, dva});
    check("count_literal_word", {16'h0, m_cnt, m_lit}, {16'h0, clw});
    check("count_overflow", {31'h0, m_ovf}, {31'h0, ovf});
  end

  // Clock generator
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Main sequence: reset, random control traffic, counter wrap, register reads
  initial begin
    {rst_n, ld_lo, src, ld_b1, ld_b2, ld_c, inc_c, pick, ld_lit, chk} = '0;
    {cyc, stb, we, adr, sel, wdat, sh_raw, st_raw} = '0;
    seed = 32'hD; err_count = 0; n_tests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1; chk <= 1'h1;
    repeat (3000) begin
      @(posedge clk);
      seed = xs(seed);
      {ld_lo, src, ld_b1, ld_b2, inc_c, pick, ld_lit} <= seed[6:0];
      ld_c <= seed[9] & seed[10];
      sh_raw <= xs(seed ^ 32'h5A5A5A5A); st_raw <= seed[31:16];
    end
    rst_n <= 1'h0; // Mid-run reset must clear every register again
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk); // Counter from FF wraps to 00 and raises overflow
    {ld_lo, src, ld_b1, ld_b2, ld_c, inc_c, pick, ld_lit} <= 8'h01; st_raw <= 16'h00FF;
    repeat (3) @(posedge clk);
    {ld_c, inc_c, ld_lit} <= 3'h4;
    @(posedge clk);
    {ld_c, inc_c} <= 2'h1;
    repeat (2) @(posedge clk);
    inc_c <= 1'h0;
    @(posedge clk);
    wb(1'h1, 6'h00, 32'h1, 32'h0);
    wb(1'h0, 6'h00, 32'h0, {31'h0, m_ctl});
    wb(1'h1, 6'h01, 32'hA5, 32'h0);
    wb(1'h0, 6'h01, 32'h0, {24'h0, m_lo});
    wb(1'h0, 6'h02, 32'h0, {24'h0, m_b1});
    wb(1'h0, 6'h03, 32'h0, {24'h0, m_b2});
    wb(1'h0, 6'h04, 32'h0, {16'h0, e_out});
    wb(1'h0, 6'h05, 32'h0, {15'h0, m_ovf, m_cnt, m_lit});
    wb(1'h0, 6'h06, 32'h0, 32'h0);
    wb(1'h1, 6'h00, 32'h0, 32'h0);
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule : test_memory_device_address_regs

`default_nettype wire
